//--- rtl/qrd_device.sv
// The address map and register access over APB were decided locally.
`include "qrd_params.svh"

module qrd_device (
	input  wire logic        clk,
	input  wire logic        rst_b,
	qrd_if.device            link,
	input  wire logic        ra_supported,
	input  wire logic        ra_enabled,
	output logic             media_req,
	output logic [47:0]      media_lba,
	output logic             media_rebuild,
	input  wire logic        media_ack,
	input  wire logic        media_uncorr,
	input  wire logic        media_idnf,
	input  wire logic        crc_err,
	output logic             busy
);
	localparam int NS = `QRD_SLOTS;

	qrd_pkg::qrd_dev_state_t state;

	logic        s_valid [NS];
	logic        s_ok    [NS];
	logic        s_rebuild [NS];
	logic [4:0]  s_tag   [NS];
	logic [1:0]  s_priority [NS];
	logic [16:0] s_cnt   [NS];
	logic [47:0] s_lba   [NS];

	logic        a_ok;
	logic        a_rebuild;
	logic [4:0]  a_tag;
	logic [16:0] a_rem;
	logic [47:0] a_lba;
	logic [47:0] rep_lba;
	logic [7:0]  err;

	logic        accept;
	logic        take;
	logic        fill;
	logic        pick;
	logic [15:0] req_cnt;
	logic [16:0] req_len;
	logic        next_full;
	logic        any_valid;

	assign accept    = link.cmd_valid && link.cmd_ready;
	assign fill      = s_valid[0];
	assign any_valid = s_valid[0] || s_valid[1];
	assign take      = (state == qrd_pkg::QRD_D_IDLE) && any_valid;
	// high priority entry overtakes an older non-high one
	assign pick      = s_valid[1] && (!s_valid[0] ||
		(s_priority[1] == `QRD_PRIORITY_HIGH &&
		s_priority[0] != `QRD_PRIORITY_HIGH)); // see R12
	assign req_cnt   = {link.feat_prev, link.feat_cur}; // see R6
	assign req_len   = (req_cnt == 16'h0000) ? `QRD_FULL_COUNT
		: {1'b0, req_cnt};

	generate
		for (genvar i = 0; i < NS; i++) begin : g_slot
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					s_valid[i] <= 1'b0;
					s_ok[i]    <= 1'b0;
					s_rebuild[i] <= 1'b0;
					s_tag[i]   <= 5'h00;
					s_priority[i] <= 2'h0;
					s_cnt[i]   <= 17'h00000;
					s_lba[i]   <= 48'h0000_0000_0000;
				end else if (take && pick == 1'(i)) begin
					s_valid[i] <= 1'b0;
				end else if (accept && fill == 1'(i)) begin
					s_valid[i] <= 1'b1;
					s_ok[i]    <= link.opcode == `QRD_OP_READ_QUEUED; // see R3
					s_rebuild[i] <= link.cnt_cur[`QRD_REBUILD_BIT];
					s_tag[i]   <= link.cnt_cur[7:`QRD_TAG_LSB];
					s_priority[i] <=
						link.cnt_prev[7:`QRD_PRIORITY_LSB]; // see R12
					s_cnt[i]   <= req_len;
					s_lba[i]   <= {link.lba_prev, link.lba_cur};
				end
			end
		end
	endgenerate

	// free slot count seen by the host one cycle late, so count ahead
	always_comb begin
		next_full = s_valid[0] && s_valid[1];
		if (accept) begin
			next_full = any_valid;
		end
		if (take) begin
			next_full = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link.cmd_ready <= 1'b0;
			busy           <= 1'b0;
		end else begin
			link.cmd_ready <= !next_full;
			busy           <= any_valid || state != qrd_pkg::QRD_D_IDLE;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state           <= qrd_pkg::QRD_D_IDLE;
			a_ok            <= 1'b0;
			a_rebuild       <= 1'b0;
			a_tag           <= 5'h00;
			a_rem           <= 17'h00000;
			a_lba           <= 48'h0000_0000_0000;
			err             <= 8'h00;
			media_req       <= 1'b0;
			link.xfer_valid <= 1'b0;
		end else begin
			case (state)
				qrd_pkg::QRD_D_IDLE: begin
					if (take) begin
						a_ok   <= s_ok[pick];
						a_tag  <= s_tag[pick];
						a_rem  <= s_cnt[pick];
						a_lba  <= s_lba[pick];
						// rebuild bit only honoured when usable
						a_rebuild <= s_rebuild[pick] && ra_supported
							&& ra_enabled; // see R9 see R10 see R11
						err    <= 8'h00;
						if (s_ok[pick]) begin
							state     <= qrd_pkg::QRD_D_READ;
							media_req <= 1'b1; // see R4
						end else begin
							err[`QRD_ERR_ABORTED] <= 1'b1; // see R3 see R13
							state             <= qrd_pkg::QRD_D_DONE;
						end
					end
				end
				qrd_pkg::QRD_D_READ: begin
					if (media_ack) begin
						media_req <= 1'b0;
						if (media_uncorr) begin
							err[`QRD_ERR_UNCORR] <= 1'b1; // see R5 see R13
							state             <= qrd_pkg::QRD_D_DONE;
						end else if (media_idnf) begin
							err[`QRD_ERR_NOT_FOUND] <= 1'b1; // see R13
							state             <= qrd_pkg::QRD_D_DONE;
						end else begin
							link.xfer_valid <= 1'b1; // see R4
							state           <= qrd_pkg::QRD_D_SEND;
						end
					end
				end
				qrd_pkg::QRD_D_SEND: begin
					if (link.xfer_ready) begin
						link.xfer_valid <= 1'b0;
						if (crc_err) begin
							err[`QRD_ERR_CRC] <= 1'b1; // see R13
							state             <= qrd_pkg::QRD_D_DONE;
						end else if (a_rem == 17'h00001) begin
							state <= qrd_pkg::QRD_D_DONE;
						end else begin
							a_rem     <= a_rem - 17'h00001;
							a_lba     <= a_lba + 48'h0000_0000_0001;
							media_req <= 1'b1;
							state     <= qrd_pkg::QRD_D_READ;
						end
					end
				end
				qrd_pkg::QRD_D_DONE: begin
					state <= qrd_pkg::QRD_D_IDLE;
				end
				default: begin
					state <= qrd_pkg::QRD_D_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			media_lba  <= 48'h0000_0000_0000;
			media_rebuild <= 1'b0;
		end else begin
			media_lba     <= a_lba;
			media_rebuild <= a_rebuild && a_ok; // see R11
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link.xfer_lba <= 48'h0000_0000_0000;
			link.xfer_tag <= 5'h00;
		end else begin
			link.xfer_lba <= a_lba;
			link.xfer_tag <= a_tag;
		end
	end

	// busy, fault and corrected always clear on completion
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link.done_valid <= 1'b0;
			link.done_tag   <= 5'h00;
			link.status     <= 8'h00;
			link.error      <= 8'h00;
			rep_lba         <= 48'h0000_0000_0000;
		end else begin
			link.done_valid <= state == qrd_pkg::QRD_D_DONE;
			if (state == qrd_pkg::QRD_D_DONE) begin
				link.done_tag <= a_tag;
				link.error    <= err; // see R13
				link.status   <= 8'h00;
				link.status[`QRD_ST_RDY] <= 1'b1;
				link.status[`QRD_ST_DSC] <= 1'b1;
				link.status[`QRD_ST_ERR] <= |err; // see R13
				rep_lba       <= a_lba; // see R5
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link.sn_out <= 8'h00;
			link.cl_out <= 8'h00;
			link.ch_out <= 8'h00;
		end else if (link.high_order_byte_select) begin
			link.sn_out <= rep_lba[31:24]; // see R2
			link.cl_out <= rep_lba[39:32];
			link.ch_out <= rep_lba[47:40];
		end else begin
			link.sn_out <= rep_lba[7:0]; // see R1
			link.cl_out <= rep_lba[15:8];
			link.ch_out <= rep_lba[23:16];
		end
	end
endmodule : qrd_device

//--- rtl/qrd_params.svh
// Notes on behaviour
// R1: select low: error address bits 23:0 returned
// R2: select high: error address bits 47:24 returned
// R3: opcode 60h is the queued read
// R4: read sectors from media, send to host
// R5: uncorrectable error stops at failing sector
// R6: count built from feature current and previous
// R7: host tag in bits 7-3, unique
// R8: host keeps tag within reported queue depth
// R9: rebuild bit ignored when feature unsupported
// R10: rebuild bit ignored when feature disabled
// R11: supported and enabled: rebuild processing applies
// R12: priority in bits 7-6; high served first
// R13: completion status and error bytes reported
`ifndef QRD_PARAMS_SVH
`define QRD_PARAMS_SVH

`define QRD_OP_READ_QUEUED 8'h60
`define QRD_DEV_HEAD       8'h40
`define QRD_PRIORITY_NORMAL 2'h0
`define QRD_PRIORITY_ISOCH  2'h1
`define QRD_PRIORITY_HIGH   2'h2
`define QRD_TAG_LSB         3
`define QRD_REBUILD_BIT     0
`define QRD_PRIORITY_LSB    6
`define QRD_ERR_CRC         7
`define QRD_ERR_UNCORR      6
`define QRD_ERR_NOT_FOUND   4
`define QRD_ERR_ABORTED     2
`define QRD_ST_RDY         6
`define QRD_ST_DSC         4
`define QRD_ST_ERR         0
`define QRD_FULL_COUNT     17'h10000
`define QRD_SLOTS          2

`define QRD_REG_CTRL       8'h00
`define QRD_REG_COUNT      8'h04
`define QRD_REG_LBA_LO     8'h08
`define QRD_REG_LBA_HI     8'h0C
`define QRD_REG_OPTS       8'h10
`define QRD_REG_STATUS     8'h14
`define QRD_REG_FAIL_LO    8'h18
`define QRD_REG_FAIL_HI    8'h1C
`define QRD_REG_SECTORS    8'h20
`define QRD_CTRL_GO        0
`define QRD_CTRL_CLR       1
`define QRD_OPTS_RESET     32'h0000_6000

`endif

//--- rtl/qrd_pkg.sv
package qrd_pkg;
	typedef enum logic [1:0] {
		QRD_D_IDLE,
		QRD_D_READ,
		QRD_D_SEND,
		QRD_D_DONE
	} qrd_dev_state_t;

	typedef enum logic [2:0] {
		QRD_H_IDLE,
		QRD_H_ISSUE,
		QRD_H_WAIT,
		QRD_H_READBACK,
		QRD_H_FIN
	} qrd_host_state_t;
endpackage : qrd_pkg

//--- rtl/qrd_if.sv
interface qrd_if;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [7:0]  opcode;
	logic [7:0]  feat_cur;
	logic [7:0]  feat_prev;
	logic [7:0]  cnt_cur;
	logic [7:0]  cnt_prev;
	logic [23:0] lba_cur;
	logic [23:0] lba_prev;
	logic [7:0]  dev_head;
	logic        high_order_byte_select;
	logic        xfer_valid;
	logic        xfer_ready;
	logic [47:0] xfer_lba;
	logic [4:0]  xfer_tag;
	logic        done_valid;
	logic [4:0]  done_tag;
	logic [7:0]  status;
	logic [7:0]  error;
	logic [7:0]  sn_out;
	logic [7:0]  cl_out;
	logic [7:0]  ch_out;

	modport host (
		output cmd_valid, opcode, feat_cur, feat_prev, cnt_cur, cnt_prev,
		output lba_cur, lba_prev, dev_head, high_order_byte_select,
		output xfer_ready,
		input  cmd_ready, xfer_valid, xfer_lba, xfer_tag, done_valid,
		input  done_tag, status, error, sn_out, cl_out, ch_out
	);
	modport device (
		input  cmd_valid, opcode, feat_cur, feat_prev, cnt_cur, cnt_prev,
		input  lba_cur, lba_prev, dev_head, high_order_byte_select,
		input  xfer_ready,
		output cmd_ready, xfer_valid, xfer_lba, xfer_tag, done_valid,
		output done_tag, status, error, sn_out, cl_out, ch_out
	);
endinterface : qrd_if

//--- rtl/qrd_host.sv
`include "qrd_params.svh"

module qrd_host (
	input  wire logic        clk,
	input  wire logic        rst_b,
	qrd_if.host              link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             sec_valid,
	output logic [47:0]      sec_lba
);
	qrd_pkg::qrd_host_state_t state;

	logic [15:0] count;
	logic [47:0] lba;
	logic [31:0] opts;
	logic [7:0]  st_byte;
	logic [7:0]  er_byte;
	logic [4:0]  dn_tag;
	logic        done;
	logic [47:0] fail;
	logic [31:0] sectors;
	logic [2:0]  step;
	logic        setup;
	logic        wr;
	logic        go;
	logic        mapped;
	logic [31:0] rd;

	assign setup = psel && !penable;
	assign wr    = psel && penable && pready && pwrite;
	assign go    = wr && paddr == `QRD_REG_CTRL && pwdata[`QRD_CTRL_GO];

	always_comb begin
		mapped = 1'b1;
		rd     = 32'h0000_0000;
		case (paddr)
			`QRD_REG_CTRL:    rd = 32'h0000_0000;
			`QRD_REG_COUNT:   rd = {16'h0000, count};
			`QRD_REG_LBA_LO:  rd = lba[31:0];
			`QRD_REG_LBA_HI:  rd = {16'h0000, lba[47:32]};
			`QRD_REG_OPTS:    rd = opts;
			`QRD_REG_STATUS:  rd = {9'h000, dn_tag, done,
				state != qrd_pkg::QRD_H_IDLE, er_byte, st_byte};
			`QRD_REG_FAIL_LO: rd = fail[31:0];
			`QRD_REG_FAIL_HI: rd = {16'h0000, fail[47:32]};
			`QRD_REG_SECTORS: rd = sectors;
			default:          mapped = 1'b0;
		endcase
	end

	// answer lands in the first access cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			prdata  <= (setup && !pwrite) ? rd : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= 16'h0001;
			lba   <= 48'h0000_0000_0000;
			opts  <= `QRD_OPTS_RESET;
		end else if (wr && state == qrd_pkg::QRD_H_IDLE) begin
			case (paddr)
				`QRD_REG_COUNT:  count      <= pwdata[15:0];
				`QRD_REG_LBA_LO: lba[31:0]  <= pwdata;
				`QRD_REG_LBA_HI: lba[47:32] <= pwdata[15:0];
				`QRD_REG_OPTS:   opts       <= pwdata;
				default:         count      <= count;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state          <= qrd_pkg::QRD_H_IDLE;
			link.cmd_valid <= 1'b0;
			link.high_order_byte_select <= 1'b0;
			link.xfer_ready <= 1'b0;
			step           <= 3'h0;
		end else begin
			case (state)
				qrd_pkg::QRD_H_IDLE: begin
					if (go) begin
						link.cmd_valid <= 1'b1;
						state          <= qrd_pkg::QRD_H_ISSUE;
					end
				end
				qrd_pkg::QRD_H_ISSUE: begin
					if (link.cmd_ready) begin
						link.cmd_valid  <= 1'b0;
						link.xfer_ready <= 1'b1;
						state           <= qrd_pkg::QRD_H_WAIT;
					end
				end
				qrd_pkg::QRD_H_WAIT: begin
					if (link.done_valid) begin
						link.xfer_ready <= 1'b0;
						step            <= 3'h0;
						state           <= qrd_pkg::QRD_H_READBACK;
					end
				end
				qrd_pkg::QRD_H_READBACK: begin
					step <= step + 3'h1;
					if (step == 3'h1) begin
						link.high_order_byte_select <= 1'b1; // see R2
					end
					if (step == 3'h3) begin
						link.high_order_byte_select <= 1'b0;
						state        <= qrd_pkg::QRD_H_FIN;
					end
				end
				qrd_pkg::QRD_H_FIN: begin
					state <= qrd_pkg::QRD_H_IDLE;
				end
				default: begin
					state <= qrd_pkg::QRD_H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link.opcode    <= 8'h00;
			link.feat_cur  <= 8'h00;
			link.feat_prev <= 8'h00;
			link.cnt_cur   <= 8'h00;
			link.cnt_prev  <= 8'h00;
			link.lba_cur   <= 24'h00_0000;
			link.lba_prev  <= 24'h00_0000;
			link.dev_head  <= 8'h00;
		end else if (go && state == qrd_pkg::QRD_H_IDLE) begin
			link.opcode    <= opts[15:8]; // see R3
			link.feat_cur  <= count[7:0]; // see R6
			link.feat_prev <= count[15:8];
			link.cnt_cur   <= {opts[4:0], 2'h0, opts[5]}; // see R7 see R8
			link.cnt_prev  <= {opts[7:6], 6'h00}; // see R12
			link.lba_cur   <= lba[23:0];
			link.lba_prev  <= lba[47:24];
			link.dev_head  <= `QRD_DEV_HEAD;
		end
	end

	// done is sticky; a completion in the clearing cycle wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done    <= 1'b0;
			st_byte <= 8'h00;
			er_byte <= 8'h00;
			dn_tag  <= 5'h00;
			fail    <= 48'h0000_0000_0000;
		end else begin
			if (state == qrd_pkg::QRD_H_FIN) begin
				done <= 1'b1;
			end else if (wr && paddr == `QRD_REG_CTRL
				&& pwdata[`QRD_CTRL_CLR]) begin
				done <= 1'b0;
			end
			if (link.done_valid && state == qrd_pkg::QRD_H_WAIT) begin
				st_byte <= link.status;
				er_byte <= link.error;
				dn_tag  <= link.done_tag;
			end
			if (state == qrd_pkg::QRD_H_READBACK && step == 3'h1) begin
				fail[23:0] <= {link.ch_out, link.cl_out, link.sn_out}; // see R1
			end
			if (state == qrd_pkg::QRD_H_READBACK && step == 3'h3) begin
				fail[47:24] <= {link.ch_out, link.cl_out, link.sn_out}; // see R2
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sec_valid <= 1'b0;
			sec_lba   <= 48'h0000_0000_0000;
			sectors   <= 32'h0000_0000;
		end else begin
			sec_valid <= link.xfer_valid && link.xfer_ready;
			sec_lba   <= link.xfer_lba;
			if (go && state == qrd_pkg::QRD_H_IDLE) begin
				sectors <= 32'h0000_0000;
			end else if (link.xfer_valid && link.xfer_ready) begin
				sectors <= sectors + 32'h0000_0001;
			end
		end
	end
endmodule : qrd_host

//--- test/qrd_assertions.sv
module qrd_assertions (
	input logic        clk,
	input logic        rst_b,
	input logic        cmd_valid,
	input logic        cmd_ready,
	input logic [7:0]  opcode,
	input logic [7:0]  feat_cur,
	input logic [7:0]  feat_prev,
	input logic [23:0] lba_cur,
	input logic [23:0] lba_prev,
	input logic        high_order_byte_select,
	input logic        xfer_valid,
	input logic        xfer_ready,
	input logic [47:0] xfer_lba,
	input logic        done_valid,
	input logic [7:0]  status,
	input logic [7:0]  error,
	input logic [7:0]  sn_out,
	input logic [7:0]  cl_out,
	input logic [7:0]  ch_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [47:0] nxt;
	logic [47:0] rep;
	logic [16:0] sent;
	logic [16:0] want;
	logic        ok;
	logic        stop;
	wire         cmd = cmd_valid && cmd_ready;
	wire         hs  = xfer_valid && xfer_ready;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// next expected sector address and running sector count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			nxt  <= '0;
			rep  <= '0;
			sent <= '0;
			want <= '0;
		end else if (cmd) begin
			nxt  <= {lba_prev, lba_cur};
			want <= ({feat_prev, feat_cur} == 16'h0000) ? 17'h10000
				: {1'b0, feat_prev, feat_cur};
			sent <= '0;
		end else if (hs) begin
			nxt  <= xfer_lba + 48'h1;
			rep  <= xfer_lba;
			sent <= sent + 17'h1;
		end
	end

	// clean completion seen, or completion that ended on a media error
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ok   <= 1'b0;
			stop <= 1'b0;
		end else if (cmd) begin
			ok   <= 1'b0;
			stop <= 1'b0;
		end else if (done_valid) begin
			ok   <= (error == 8'h00);
			stop <= error[6] | error[4];
		end
	end

	chk_addr_low: assert property (
		ok && $past(ok) && !$past(high_order_byte_select)
		|-> {ch_out, cl_out, sn_out} == rep[23:0])
		else $error("low address bytes wrong");
	chk_addr_high: assert property (
		ok && $past(ok) && $past(high_order_byte_select)
		|-> {ch_out, cl_out, sn_out} == rep[47:24])
		else $error("high address bytes wrong");
	chk_bad_opcode: assert property (
		cmd && opcode != 8'h60 |=> !xfer_valid throughout
		(1'b1 ##[1:12] (done_valid && error[2])))
		else $error("unknown opcode not aborted");
	chk_xfer_hold: assert property (
		xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_lba))
		else $error("sector offer dropped or changed");
	chk_lba_order: assert property (xfer_valid |-> xfer_lba == nxt)
		else $error("sector address out of order");
	chk_stop_uncorr: assert property (stop |-> !xfer_valid)
		else $error("sector sent after media error");
	chk_sector_count: assert property (
		done_valid && error == 8'h00 |-> sent == want)
		else $error("sector count wrong at completion");
	chk_status_bits: assert property (
		done_valid |-> status == {7'h28, |error})
		else $error("status byte wrong");
	chk_error_bits: assert property (
		done_valid |-> (error & 8'h2B) == 8'h00 ##1 !done_valid)
		else $error("error byte or done pulse wrong");
endmodule : qrd_assertions

//--- test/queued_read_command_decode_tb.sv
`include "qrd_params.svh"

module queued_read_command_decode_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic        sec_valid, ra_supported, ra_enabled, crc_err, dev_busy;
	logic [47:0] sec_lba, media_lba, uncorr_lba, idnf_lba, a;
	logic        media_req, media_rebuild, media_ack, media_uncorr;
	logic        media_idnf, req_d, rd_chk, exp_rebuild;
	logic [1:0]  wcnt;
	logic [32:0] exp_rd[$];
	logic [47:0] exp_sec[$];
	logic [7:0]  ops[3] = '{8'h25, 8'h61, 8'hE0};
	int          num_errors, total_checks, cycles;

	qrd_if qrd_if_i ();
	qrd_host qrd_host_i (.clk(clk), .rst_b(rst_b), .link(qrd_if_i),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sec_valid(sec_valid), .sec_lba(sec_lba));
	qrd_device qrd_device_i (.clk(clk), .rst_b(rst_b), .link(qrd_if_i),
		.ra_supported(ra_supported), .ra_enabled(ra_enabled),
		.media_req(media_req), .media_lba(media_lba),
		.media_rebuild(media_rebuild), .media_ack(media_ack),
		.media_uncorr(media_uncorr), .media_idnf(media_idnf),
		.crc_err(crc_err), .busy(dev_busy));
	qrd_assertions qrd_assertions_i (.clk(clk), .rst_b(rst_b),
		.cmd_valid(qrd_if_i.cmd_valid), .cmd_ready(qrd_if_i.cmd_ready),
		.opcode(qrd_if_i.opcode), .feat_cur(qrd_if_i.feat_cur),
		.feat_prev(qrd_if_i.feat_prev), .lba_cur(qrd_if_i.lba_cur),
		.lba_prev(qrd_if_i.lba_prev),
		.high_order_byte_select(qrd_if_i.high_order_byte_select),
		.xfer_valid(qrd_if_i.xfer_valid), .xfer_ready(qrd_if_i.xfer_ready),
		.xfer_lba(qrd_if_i.xfer_lba), .done_valid(qrd_if_i.done_valid),
		.status(qrd_if_i.status), .error(qrd_if_i.error),
		.sn_out(qrd_if_i.sn_out), .cl_out(qrd_if_i.cl_out),
		.ch_out(qrd_if_i.ch_out));

	always #10 clk = ~clk;

	task check(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : check

	task finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
		input logic c, input logic [32:0] e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		rd_chk <= c;
		if (c)
			exp_rd.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_data = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		rd_chk <= 1'b0;
	endtask : apb

	// opt is {priority, rebuild bit, tag}
	task run(input logic [15:0] n, input logic [7:0] op,
		input logic [7:0] opt, input int ns, input logic [7:0] er,
		input logic [47:0] fa, input logic cf);
		apb(1'b1, `QRD_REG_COUNT, {16'h0, n}, 1'b0, '0);
		apb(1'b1, `QRD_REG_LBA_LO, a[31:0], 1'b0, '0);
		apb(1'b1, `QRD_REG_LBA_HI, {16'h0, a[47:32]}, 1'b0, '0);
		apb(1'b1, `QRD_REG_OPTS, {16'h0, op, opt}, 1'b0, '0);
		for (int i = 0; i < ns; i++)
			exp_sec.push_back(a + 48'(i));
		apb(1'b1, `QRD_REG_CTRL, 32'h1, 1'b0, '0);
		rd_data = '0;
		while (rd_data[17] !== 1'b1)
			apb(1'b0, `QRD_REG_STATUS, '0, 1'b0, '0);
		apb(1'b0, `QRD_REG_STATUS, '0, 1'b1,
			{10'h0, opt[4:0], 2'b10, er, 7'h28, |er});
		check(48'(dev_busy), 48'h0);
		if (cf) begin
			apb(1'b0, `QRD_REG_FAIL_LO, '0, 1'b1, {1'b0, fa[31:0]});
			apb(1'b0, `QRD_REG_FAIL_HI, '0, 1'b1, {17'h0, fa[47:32]});
		end
		apb(1'b0, `QRD_REG_SECTORS, '0, 1'b1, 33'(ns));
		apb(1'b1, `QRD_REG_CTRL, 32'h2, 1'b0, '0);
	endtask : run

	// media side: acknowledges each request after a random stall
	always @(posedge clk) begin
		req_d <= media_req;
		media_ack <= 1'b0;
		media_uncorr <= 1'b0;
		media_idnf <= 1'b0;
		if (media_req && req_d && !media_ack) begin
			if (wcnt == 2'h0) begin
				media_ack <= 1'b1;
				media_uncorr <= (media_lba === uncorr_lba);
				media_idnf <= (media_lba === idnf_lba);
				wcnt <= 2'($urandom);
				check(48'(media_rebuild), 48'(exp_rebuild));
				check(48'(dev_busy), 48'h1);
			end else
				wcnt <= wcnt - 2'h1;
		end
	end

	always @(posedge clk) begin
		if (psel && penable && pready && rd_chk)
			check(48'({pslverr, prdata}), 48'(exp_rd.pop_front()));
		if (sec_valid)
			check(sec_lba, exp_sec.pop_front());
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end

	initial begin
		void'($urandom(32'h356941FF));
		{clk, rst_b, psel, penable, pwrite, rd_chk, req_d} = '0;
		{ra_supported, ra_enabled, crc_err, exp_rebuild, wcnt} = '0;
		{media_ack, media_uncorr, media_idnf, paddr, pwdata} = '0;
		{uncorr_lba, idnf_lba} = '1;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, `QRD_REG_OPTS, '0, 1'b1, {1'b0, `QRD_OPTS_RESET});
		apb(1'b0, `QRD_REG_COUNT, '0, 1'b1, 33'h1);
		apb(1'b1, 8'h40, 32'h5A, 1'b0, '0);
		apb(1'b0, 8'h40, '0, 1'b1, {1'b1, 32'h0});
		a = {16'($urandom), $urandom};
		run(16'h0003, 8'h60, {2'b10, 1'b0, 5'($urandom)}, 3, 8'h00,
			a + 48'h2, 1'b1);
		run(16'h0100, 8'h60, 8'h1F, 256, 8'h00, a + 48'hFF, 1'b1);
		uncorr_lba = a + 48'h2;
		run(16'h0004, 8'h60, 8'h03, 2, 8'h40, uncorr_lba, 1'b1);
		uncorr_lba = '1;
		idnf_lba = a;
		run(16'h0002, 8'h60, 8'h04, 0, 8'h10, a, 1'b1);
		idnf_lba = '1;
		foreach (ops[i])
			run(16'h0001, ops[i], 8'h05, 0, 8'h04, '0, 1'b0);
		for (int k = 0; k < 4; k++) begin
			ra_supported <= k[0];
			ra_enabled <= k[1];
			exp_rebuild = (k == 3);
			run(16'h0001, 8'h60, {2'b01, 1'b1, 5'(k)}, 1, 8'h00, a,
				1'b1);
		end
		exp_rebuild = 1'b0;
		crc_err <= 1'b1;
		run(16'h0001, 8'h60, 8'h06, 1, 8'h80, '0, 1'b0);
		crc_err <= 1'b0;
		check(48'(exp_sec.size()), 48'h0);
		finish_test();
	end
endmodule : queued_read_command_decode_tb
